// *** core/nfc_host.sv ***
/*
 Host controller for a parallel NOR flash: turns one user request into pin
 cycles (chip select, write strobe, output enable, hardware reset) and polls
 completion of program, erase and resume. Assumes flash pins are synchronous to mclk and the flash
 meets its access time within the read wait.
*/
`timescale 1ns/1ns
module nfc_host
   import nfc_pkg::*;
(
   input wire logic mclk, // 10 MHz clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic byte_mode, // 1: x8 bus, 0: x16 bus
   input wire logic req_valid, // Request strobe
   output logic req_ready, // Controller idle
   input wire nfc_pkg::nfc_op_t req_op, // Requested operation
   input wire logic [ADDR_W:0] req_addr, // Word address, or byte address in x8
   input wire logic [DATA_W-1:0] req_wdata, // Program data
   output logic rsp_valid, // One-cycle completion pulse
   output nfc_pkg::nfc_result_t rsp_result, // Outcome
   output logic [DATA_W-1:0] rsp_rdata, // Read data
   output logic short_mode, // Short-program mode in use
   output logic region_mode, // Secured region mapped in
   output logic [ADDR_W-1:0] flash_addr, // Address pins
   output logic flash_a_lsb, // Byte-select low address bit in x8
   output logic [DATA_W-1:0] flash_dq_o, // Data out
   input wire logic [DATA_W-1:0] flash_dq_i, // Data in
   output logic flash_dq_oe_b, // Data output enable, low drives
   output logic flash_ce_b, // Chip select
   output logic flash_we_b, // Write strobe
   output logic flash_oe_b, // Output enable
   output logic flash_reset_b, // Hardware reset
   input wire logic ready_busy_output // Device ready, low while busy
);
   import nfc_pkg::*;

   typedef enum logic [3:0] {
      NFC_IDLE, NFC_WR_SETUP, NFC_WR_PULSE, NFC_WR_HOLD, NFC_RD_WAIT, NFC_RD_DONE,
      NFC_POLL, NFC_RST_PULSE, NFC_RST_REC, NFC_DONE
   } nfc_state_t;

   nfc_state_t state;
   nfc_op_t op;
   logic [2:0] step;
   logic [2:0] last_step;
   logic [ADDR_W:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [3:0] cnt;
   logic [24:0] poll_cnt;
   logic [DATA_W-1:0] prev_dq;
   logic have_prev;
   logic [ADDR_W:0] cyc_addr;
   logic [7:0] cyc_cmd;
   logic cyc_is_data;

   // Number of bus writes each operation needs, less one
   function automatic logic [2:0] seq_last(input nfc_op_t o, input logic sh);
      unique case (o)
         NFC_OP_PROGRAM: seq_last = sh ? 3'h1 : 3'h3;
         NFC_OP_ERASE: seq_last = 3'h5;
         NFC_OP_SHORT_ENTER, NFC_OP_REGION_ENTER, NFC_OP_REGION_EXIT: seq_last = 3'h2;
         NFC_OP_SHORT_EXIT: seq_last = 3'h1;
         default: seq_last = 3'h0;
      endcase
   endfunction : seq_last

   // Whether an operation ends by polling the device
   function automatic logic needs_poll(input nfc_op_t o);
      needs_poll = (o == NFC_OP_PROGRAM) || (o == NFC_OP_ERASE) || (o == NFC_OP_RESUME);
   endfunction : needs_poll

   // Unlock address in x16 terms, doubled plus one for the x8 bus
   function automatic logic [ADDR_W:0] unl(input logic [ADDR_W-1:0] a, input logic bm);
      unl = bm ? {a, 1'b0} | 21'h000001 : {1'b0, a};
   endfunction : unl

   // Address and command of the current write cycle
   always_comb begin
      cyc_is_data = 1'b0;
      cyc_addr = unl(UNLOCK_A1, byte_mode);
      cyc_cmd = CMD_READ_RESET;
      if ((op == NFC_OP_PROGRAM && short_mode) || op == NFC_OP_SHORT_EXIT) begin
         if (step == 3'h0) begin
            cyc_addr = addr;
            cyc_cmd = (op == NFC_OP_PROGRAM) ? CMD_PROGRAM : CMD_SHORT_EXIT1;
         end else begin
            cyc_addr = addr;
            cyc_cmd = CMD_SHORT_EXIT2;
            cyc_is_data = (op == NFC_OP_PROGRAM);
         end
      end else if (op == NFC_OP_SUSPEND || op == NFC_OP_RESUME || op == NFC_OP_RESET) begin
         cyc_addr = addr;
         cyc_cmd = (op == NFC_OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
      end else if (op == NFC_OP_PROGRAM && step == 3'h3) begin
         // Fourth write of a full program carries the data to the target word
         cyc_addr = addr;
         cyc_cmd = CMD_PROGRAM;
         cyc_is_data = 1'b1;
      end else begin
         unique case (step)
            3'h0, 3'h3: cyc_cmd = UNLOCK_D1;
            3'h1, 3'h4: begin
               cyc_addr = unl(UNLOCK_A2, byte_mode);
               cyc_cmd = UNLOCK_D2;
            end
            3'h2: unique case (op)
               NFC_OP_PROGRAM: cyc_cmd = CMD_PROGRAM;
               NFC_OP_ERASE: cyc_cmd = CMD_ERASE_SETUP;
               NFC_OP_SHORT_ENTER: cyc_cmd = CMD_SHORT_ENTER;
               NFC_OP_REGION_ENTER: cyc_cmd = CMD_REGION_ENTER;
               default: cyc_cmd = CMD_REGION_EXIT;
            endcase
            default: begin
               cyc_addr = addr;
               cyc_cmd = CMD_SECTOR_ERASE;
               cyc_is_data = (op == NFC_OP_PROGRAM);
            end
         endcase
      end
   end

   assign req_ready = (state == NFC_IDLE);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state <= NFC_IDLE;
         op <= NFC_OP_READ;
         step <= 3'h0;
         last_step <= 3'h0;
         addr <= '0;
         wdata <= '0;
         cnt <= 4'h0;
      end else begin
         unique case (state)
            NFC_IDLE: if (req_valid) begin
               op <= req_op;
               addr <= req_addr;
               wdata <= byte_mode ? {8'h00, req_wdata[7:0]} : req_wdata;
               step <= 3'h0;
               last_step <= seq_last(req_op, short_mode);
               cnt <= 4'h0;
               if (req_op == NFC_OP_READ) state <= NFC_RD_WAIT;
               else if (req_op == NFC_OP_RESET) state <= NFC_RST_PULSE;
               else state <= NFC_WR_SETUP;
            end
            NFC_WR_SETUP: state <= NFC_WR_PULSE;
            NFC_WR_PULSE: begin
               cnt <= cnt + 4'h1;
               if (cnt == 4'(N_WRITE_PULSE - 1)) state <= NFC_WR_HOLD;
            end
            NFC_WR_HOLD: begin
               cnt <= 4'h0;
               if (step != last_step) begin
                  step <= step + 3'h1;
                  state <= NFC_WR_SETUP;
               end else begin
                  state <= needs_poll(op) ? NFC_POLL : NFC_DONE;
               end
            end
            NFC_RD_WAIT: begin
               cnt <= cnt + 4'h1;
               if (cnt == 4'(N_READ_ACCESS - 1)) state <= NFC_RD_DONE;
            end
            NFC_RD_DONE: state <= NFC_DONE;
            NFC_POLL: if (rsp_valid) state <= NFC_IDLE;
            NFC_RST_PULSE: begin
               cnt <= cnt + 4'h1;
               if (cnt == 4'(N_RESET_PULSE - 1)) begin
                  cnt <= 4'h0;
                  state <= NFC_RST_REC;
               end
            end
            NFC_RST_REC: begin
               cnt <= cnt + 4'h1;
               if (cnt == 4'(N_RECOVER - 1)) state <= NFC_DONE;
            end
            NFC_DONE: state <= NFC_IDLE;
            default: state <= NFC_IDLE;
         endcase
      end
   end

   // Pin drivers; data is driven only while output enable is high
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         flash_ce_b <= 1'b1;
         flash_we_b <= 1'b1;
         flash_oe_b <= 1'b1;
         flash_dq_oe_b <= 1'b1;
         flash_reset_b <= 1'b1;
         flash_addr <= '0;
         flash_a_lsb <= 1'b0;
         flash_dq_o <= '0;
      end else begin
         flash_reset_b <= !(state == NFC_IDLE && req_valid && req_op == NFC_OP_RESET)
            && !(state == NFC_RST_PULSE && cnt != 4'(N_RESET_PULSE - 1));
         flash_we_b <= !(state == NFC_WR_SETUP || (state == NFC_WR_PULSE
            && cnt != 4'(N_WRITE_PULSE - 1)));
         flash_dq_oe_b <= !(state == NFC_WR_SETUP || state == NFC_WR_PULSE);
         flash_oe_b <= !((state == NFC_IDLE && req_valid && req_op == NFC_OP_READ)
            || state == NFC_RD_WAIT
            || (state == NFC_POLL && !rsp_valid));
         // Select released when idle so the device can drop to standby
         flash_ce_b <= !(flash_oe_b == 1'b0 || state == NFC_WR_SETUP
            || state == NFC_WR_PULSE || (state == NFC_IDLE && req_valid
            && req_op == NFC_OP_READ) || state == NFC_POLL);
         if (state == NFC_IDLE && req_valid) begin
            flash_addr <= byte_mode ? req_addr[ADDR_W:1] : req_addr[ADDR_W-1:0];
            flash_a_lsb <= byte_mode & req_addr[0];
         end else if (state == NFC_WR_SETUP) begin
            flash_addr <= byte_mode ? cyc_addr[ADDR_W:1] : cyc_addr[ADDR_W-1:0];
            flash_a_lsb <= byte_mode & cyc_addr[0];
            flash_dq_o <= cyc_is_data ? wdata : {8'h00, cyc_cmd};
         end else if (state == NFC_POLL || state == NFC_IDLE) begin
            flash_addr <= byte_mode ? addr[ADDR_W:1] : addr[ADDR_W-1:0];
            flash_a_lsb <= byte_mode & addr[0];
         end
      end
   end

   // Completion by toggle bit; bit seven is checked against the data on a program only
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         poll_cnt <= '0;
         prev_dq <= '0;
         have_prev <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_result <= NFC_OK;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (state != NFC_POLL || rsp_valid) begin
            poll_cnt <= '0;
            have_prev <= 1'b0;
         end else if (!flash_oe_b) begin
            poll_cnt <= poll_cnt + 25'h1;
            prev_dq <= flash_dq_i;
            have_prev <= 1'b1;
            // Stable toggle bit with ready high means the operation ended
            if (have_prev && prev_dq[6] == flash_dq_i[6] && ready_busy_output) begin
               rsp_valid <= 1'b1;
               // Rejected writes (protected sector, locked region, low supply) end
               // with the data not matching
               rsp_result <= (op != NFC_OP_PROGRAM || flash_dq_i[7] == wdata[7])
                  ? NFC_OK : NFC_FAIL;
               rsp_rdata <= flash_dq_i;
            end else if (poll_cnt == 25'(POLL_LIMIT)) begin
               rsp_valid <= 1'b1;
               rsp_result <= NFC_TIMEOUT;
            end
         end
         if (state == NFC_RD_DONE) rsp_rdata <= byte_mode ? {8'h00, flash_dq_i[7:0]}
            : flash_dq_i;
         if (state == NFC_DONE) begin
            rsp_valid <= 1'b1;
            rsp_result <= NFC_OK;
         end
      end
   end

   // Mode flags track what the device has been told
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         short_mode <= 1'b0;
         region_mode <= 1'b0;
      end else if (state == NFC_DONE) begin
         if (op == NFC_OP_SHORT_ENTER) short_mode <= 1'b1;
         if (op == NFC_OP_SHORT_EXIT || op == NFC_OP_RESET) short_mode <= 1'b0;
         if (op == NFC_OP_REGION_ENTER) region_mode <= 1'b1;
         if (op == NFC_OP_REGION_EXIT || op == NFC_OP_RESET) region_mode <= 1'b0;
      end
   end
endmodule : nfc_host

// *** core/nfc_pkg.sv ***
/*
 Package for the parallel NOR flash host controller: pin timing counts,
 command codes, unlock addresses and enumerations.
 Assumes a 10 MHz mclk; command codes are plain defaults, not fixed values.
*/
package nfc_pkg;
   localparam int CLK_NS = 100;
   localparam int T_WRITE_PULSE_NS = 100;
   localparam int T_READ_ACCESS_NS = 100;
   localparam int T_RESET_PULSE_NS = 500;
   localparam int T_RECOVER_NS = 200;
   localparam int N_WRITE_PULSE = (T_WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int N_READ_ACCESS = (T_READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int N_RESET_PULSE = (T_RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int N_RECOVER = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int POLL_LIMIT = 20000000;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h00555;
   localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h002aa;
   localparam logic [7:0] UNLOCK_D1 = 8'haa;
   localparam logic [7:0] UNLOCK_D2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_SHORT_ENTER = 8'h20;
   localparam logic [7:0] CMD_SHORT_EXIT1 = 8'h90;
   localparam logic [7:0] CMD_SHORT_EXIT2 = 8'h00;
   localparam logic [7:0] CMD_REGION_ENTER = 8'h88;
   localparam logic [7:0] CMD_REGION_EXIT = 8'h90;
   localparam logic [7:0] CMD_READ_RESET = 8'hf0;
   localparam logic [DATA_W-1:0] ERASED = 16'hffff;

   typedef enum logic [3:0] {
      NFC_OP_READ, NFC_OP_PROGRAM, NFC_OP_ERASE, NFC_OP_SUSPEND, NFC_OP_RESUME,
      NFC_OP_SHORT_ENTER, NFC_OP_SHORT_EXIT, NFC_OP_REGION_ENTER,
      NFC_OP_REGION_EXIT, NFC_OP_RESET
   } nfc_op_t;

   typedef enum logic [1:0] {
      NFC_OK, NFC_FAIL, NFC_TIMEOUT
   } nfc_result_t;
endpackage : nfc_pkg

// *** tb/nfc_flash_model.sv ***
/*
 Behavioural parallel NOR flash facing the host controller.
 Assumes word-mode writes only; busy time runs in ns, no clock.
*/
`timescale 1ns/1ns
module nfc_flash_model
   import nfc_pkg::*;
#(
   parameter int BUSY_NS = 2000, // Embedded operation time
   parameter logic [4:0] PROT_SECTOR = 5'h02 // Protected 32 Kword sector
)
(
   input wire logic byte_mode, // x8 when high
   input wire logic [ADDR_W-1:0] flash_addr, // Word address
   input wire logic flash_a_lsb, // Byte select
   input wire logic [DATA_W-1:0] flash_dq_o, // Host data
   input wire logic flash_dq_oe_b, // Host drives when low
   input wire logic flash_ce_b, // Chip select
   input wire logic flash_we_b, // Write strobe
   input wire logic flash_oe_b, // Output enable
   input wire logic flash_reset_b, // Hardware reset
   output logic [DATA_W-1:0] flash_dq_i, // Resolved data bus
   output logic ready_busy_output // Low while busy
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] last = 16'h0, rd = 16'h0, w;
   logic [7:0] c;
   logic [ADDR_W-1:0] a;
   logic [2:0] step = 3'h0;
   logic shrt = 0, ers = 0, busy = 0, tgl = 0, pd7 = 0;
   time busy_until = 0;
   wire wr = !flash_ce_b && !flash_we_b && flash_reset_b;
   wire dev = !flash_ce_b && !flash_oe_b && flash_reset_b;
   function automatic logic [DATA_W-1:0] peek(input logic [ADDR_W-1:0] x);
      return mem.exists(x) ? mem[x] : ERASED;
   endfunction : peek
   always #50 busy = $time < busy_until;
   assign ready_busy_output = !busy;
   always @(negedge flash_oe_b) if (busy) tgl = !tgl;
   always @(negedge flash_oe_b or flash_addr or flash_a_lsb or busy or tgl) begin
      w = peek(flash_addr);
      if (busy) rd = {8'h00, !pd7, tgl, 6'h00};
      else if (byte_mode) rd = flash_a_lsb ? {~w[15:8], w[15:8]} : {~w[7:0], w[7:0]};
      else rd = w;
   end
   // A released bus shows the inverse of its last value, never a stale copy
   assign flash_dq_i = !flash_dq_oe_b ? flash_dq_o : dev ? rd : ~last;
   always @(flash_dq_i) if (!flash_dq_oe_b || dev) last = flash_dq_i;
   always @(negedge flash_reset_b) begin
      step = 3'h0;
      shrt = 0;
      ers = 0;
      busy_until = 0;
   end
   always @(posedge wr) begin
      #1;
      c = flash_dq_i[7:0];
      a = flash_addr;
      if (busy) step = 3'h0;
      else if (step == 3'h4) begin
         if (a[19:15] != PROT_SECTOR) mem[a] = peek(a) & flash_dq_i;
         pd7 = flash_dq_i[7];
         busy_until = $time + BUSY_NS;
         step = 3'h0;
      end else if (step == 3'h6) begin
         shrt = 0;
         step = 3'h0;
      end else if (c == CMD_READ_RESET) step = 3'h0;
      else if (shrt && c == CMD_PROGRAM) step = 3'h4;
      else if (shrt && c == CMD_SHORT_EXIT1) step = 3'h6;
      else if (step == 3'h0) step = (a == UNLOCK_A1 && c == UNLOCK_D1) ? 3'h1 : 3'h0;
      else if (step == 3'h1) step = (a == UNLOCK_A2 && c == UNLOCK_D2) ? 3'h2 : 3'h0;
      else begin
         step = c == CMD_PROGRAM ? 3'h4 : 3'h0;
         shrt = shrt || c == CMD_SHORT_ENTER;
         if (ers && c == CMD_SECTOR_ERASE && a[19:15] != PROT_SECTOR) begin
            foreach (mem[k]) if (k[19:15] == a[19:15]) mem[k] = ERASED;
            pd7 = 1;
            busy_until = $time + BUSY_NS;
         end
         ers = c == CMD_ERASE_SETUP;
      end
   end
endmodule : nfc_flash_model

// *** tb/nfc_host_props.sv ***
/*
 Checker for the flash host controller pins and answer timing.
 Assumes it is bound to nfc_host, one clock, rst_b synchronous.
*/
`timescale 1ns/1ns
module nfc_host_props
   import nfc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire nfc_pkg::nfc_op_t req_op,
   input wire logic rsp_valid,
   input wire logic short_mode,
   input wire logic region_mode,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] flash_dq_o,
   input wire logic flash_dq_oe_b,
   input wire logic flash_ce_b,
   input wire logic flash_we_b,
   input wire logic flash_oe_b,
   input wire logic flash_reset_b
);
   logic [3:0] low_cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence take_read;
      req_valid && req_ready && req_op == NFC_OP_READ;
   endsequence
   sequence take_reset;
      req_valid && req_ready && req_op == NFC_OP_RESET;
   endsequence
   // Length of the current reset pulse, in cycles
   always_ff @(posedge mclk) begin
      if (!rst_b || flash_reset_b) low_cnt <= 4'h0;
      else low_cnt <= low_cnt + 4'h1;
   end
   chk_reset_idle: assert property ($rose(rst_b) |-> flash_ce_b && flash_we_b
      && flash_oe_b && flash_dq_oe_b && flash_reset_b && !rsp_valid && !short_mode)
      else $error("pins not idle after reset");
   chk_no_contend: assert property (!flash_oe_b |-> flash_dq_oe_b && flash_we_b)
      else $error("host drives data while reading");
   chk_write_ce: assert property (!flash_we_b |-> !flash_ce_b && !flash_dq_oe_b)
      else $error("write strobe without select or data");
   chk_write_pulse: assert property ($fell(flash_we_b) |=> flash_we_b
      && $stable(flash_addr) && $stable(flash_dq_o)) else $error("bad write pulse");
   chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer longer than one cycle");
   chk_read_oe: assert property (take_read |-> ##[1:3] (!flash_oe_b && !flash_ce_b)
      ##[1:6] rsp_valid) else $error("read cycle missing");
   chk_reset_len: assert property ($rose(flash_reset_b) |-> low_cnt == 4'h5)
      else $error("reset pulse length wrong");
   chk_modes_clear: assert property (take_reset ##[1:12] rsp_valid
      |-> !short_mode && !region_mode) else $error("modes kept after reset");
endmodule : nfc_host_props

// *** tb/tb_nfc_host.sv ***
/*
 Self-checking bench for nfc_host driving the behavioural flash model.
 Assumes a 10 MHz mclk and word-mode writes.
*/
`timescale 1ns/1ns
module tb_nfc_host;
   import nfc_pkg::*;
   logic mclk = 0, rst_b = 0, byte_mode = 0, req_valid = 0;
   nfc_op_t req_op = NFC_OP_READ;
   logic [ADDR_W:0] req_addr = '0;
   logic [DATA_W-1:0] req_wdata = '0, flash_dq_o, flash_dq_i, rsp_rdata, rd;
   logic [ADDR_W-1:0] flash_addr;
   logic req_ready, rsp_valid, short_mode, region_mode, flash_a_lsb, flash_dq_oe_b;
   logic flash_ce_b, flash_we_b, flash_oe_b, flash_reset_b, ready_busy_output;
   nfc_result_t rsp_result, res;
   int n_mismatch = 0, n_compared = 0, n_wr = 0;
   initial forever #50 mclk = ~mclk;
   always @(posedge flash_we_b) n_wr++;
   nfc_host nfc_host_i (.mclk, .rst_b, .byte_mode, .req_valid, .req_ready, .req_op,
      .req_addr, .req_wdata, .rsp_valid, .rsp_result, .rsp_rdata, .short_mode,
      .region_mode, .flash_addr, .flash_a_lsb, .flash_dq_o, .flash_dq_i, .flash_dq_oe_b,
      .flash_ce_b, .flash_we_b, .flash_oe_b, .flash_reset_b, .ready_busy_output);
   nfc_flash_model nfc_flash_model_i (.byte_mode, .flash_addr, .flash_a_lsb, .flash_dq_o,
      .flash_dq_oe_b, .flash_ce_b, .flash_we_b, .flash_oe_b, .flash_reset_b,
      .flash_dq_i, .ready_busy_output);
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task automatic do_req(input nfc_op_t op, input logic [ADDR_W:0] ad, input logic [15:0] d);
      int i;
      @(posedge mclk) #1;
      req_op = op;
      req_addr = ad;
      req_wdata = d;
      req_valid = 1;
      while (req_ready !== 1'b1) @(posedge mclk) #1;
      @(posedge mclk) #1;
      req_valid = 0;
      for (i = 0; i < 3000 && rsp_valid !== 1'b1; i++) @(posedge mclk) #1;
      check("answer", rsp_valid, 16'h1);
      res = rsp_result;
      rd = rsp_rdata;
   endtask : do_req
   task automatic t_program;
      int w;
      w = n_wr;
      do_req(NFC_OP_PROGRAM, 21'h00100, 16'h1234);
      check("prog result", res, NFC_OK);
      check("prog writes", 16'(n_wr - w), 16'h4);
      do_req(NFC_OP_READ, 21'h00100, 16'h0);
      check("read back", rd, 16'h1234);
      do_req(NFC_OP_PROGRAM, 21'h00100, 16'hff0f);
      do_req(NFC_OP_READ, 21'h00100, 16'h0);
      check("reprogram", rd, 16'h1204);
   endtask : t_program
   task automatic t_erase;
      do_req(NFC_OP_PROGRAM, 21'h08000, 16'h5555);
      do_req(NFC_OP_ERASE, 21'h00123, 16'h0);
      check("erase result", res, NFC_OK);
      do_req(NFC_OP_READ, 21'h00100, 16'h0);
      check("erased word", rd, ERASED);
      do_req(NFC_OP_READ, 21'h08000, 16'h0);
      check("other sector", rd, 16'h5555);
   endtask : t_erase
   task automatic t_protect;
      do_req(NFC_OP_PROGRAM, 21'h10000, 16'h0000);
      check("protected result", res, NFC_FAIL);
      do_req(NFC_OP_READ, 21'h10000, 16'h0);
      check("protected word", rd, ERASED);
   endtask : t_protect
   task automatic t_short;
      int w;
      do_req(NFC_OP_SHORT_ENTER, 21'h0, 16'h0);
      check("short on", short_mode, 16'h1);
      w = n_wr;
      do_req(NFC_OP_PROGRAM, 21'h00300, 16'habcd);
      check("short writes", 16'(n_wr - w), 16'h2);
      do_req(NFC_OP_SHORT_EXIT, 21'h0, 16'h0);
      check("short off", short_mode, 16'h0);
      do_req(NFC_OP_READ, 21'h00300, 16'h0);
      check("short data", rd, 16'habcd);
   endtask : t_short
   task automatic t_suspend;
      int w;
      w = n_wr;
      do_req(NFC_OP_SUSPEND, 21'h00300, 16'h0);
      check("suspend result", res, NFC_OK);
      check("suspend writes", 16'(n_wr - w), 16'h1);
      do_req(NFC_OP_RESUME, 21'h00300, 16'h0);
      check("resume result", res, NFC_OK);
      check("resume data", rd, 16'habcd);
   endtask : t_suspend
   task automatic t_byte;
      byte_mode = 1;
      do_req(NFC_OP_READ, {20'h00300, 1'b1}, 16'h0);
      check("high byte", {8'h00, rd[7:0]}, 16'h00ab);
      do_req(NFC_OP_READ, {20'h00300, 1'b0}, 16'h0);
      check("low byte", {8'h00, rd[7:0]}, 16'h00cd);
      byte_mode = 0;
   endtask : t_byte
   task automatic t_region_reset;
      do_req(NFC_OP_REGION_ENTER, 21'h0, 16'h0);
      check("region on", region_mode, 16'h1);
      do_req(NFC_OP_REGION_EXIT, 21'h0, 16'h0);
      check("region exit", region_mode, 16'h0);
      do_req(NFC_OP_REGION_ENTER, 21'h0, 16'h0);
      do_req(NFC_OP_RESET, 21'h0, 16'h0);
      check("region off", region_mode, 16'h0);
      do_req(NFC_OP_READ, 21'h00300, 16'h0);
      check("read after reset", rd, 16'habcd);
   endtask : t_region_reset
   initial begin
      repeat (16) @(posedge mclk);
      #1 rst_b = 1;
      check("idle ready", req_ready, 16'h1);
      t_program;
      t_erase;
      t_protect;
      t_short;
      t_suspend;
      t_byte;
      t_region_reset;
      print_verdict;
   end
   // The whole sequence needs well under 10,000 cycles
   initial begin
      #3000000;
      n_mismatch++;
      print_verdict;
   end
endmodule : tb_nfc_host
bind nfc_host nfc_host_props nfc_host_props_i (.mclk, .rst_b, .req_valid, .req_ready,
   .req_op, .rsp_valid, .short_mode, .region_mode, .flash_addr, .flash_dq_o,
   .flash_dq_oe_b, .flash_ce_b, .flash_we_b, .flash_oe_b, .flash_reset_b);
